// File: ebi_top.sv
// buffer interrupt enable register, buffer event flags and counters
// Function
// - enable bit set allows, clear blocks interrupt
// - config bits 5:0 read identifier 001011
// - soft request write raises interrupt, sets flag
// - soft request acts once per written one
// - ready-for-transmit interrupts when enabled
// - transmit underrun sets flag, interrupts if enabled
// - underrun frame abandoned, no further attempts
// - receive miss sets flag, interrupts if enabled
// - first 128 received bytes interrupt when enabled
// - collision count step 1FFh to 200h interrupts
// - collision counter counts receive activity during transmit
// - miss count step 1FFh to 200h interrupts
// - each receive miss increments miss counter
// - address match interrupts before 128-byte event
// - with match enabled, address match report becomes 128-byte event
// - config may load from EEPROM after reset
// - reading event register clears all flags
// - event register holds ready-for-transmit flag
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "ebi_map.svh"
module ebi_top (
   // clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   // wishbone slave
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [`EBI_ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output logic      [31:0]            wb_dat_o,
   output logic                        wb_ack_o,
   // buffer events, one-cycle pulses
   input  wire logic                   tx_ready_i,
   input  wire logic                   tx_starve_i,
   input  wire logic                   rx_lost_i,
   input  wire logic                   rx_early_i,
   input  wire logic                   addr_match_i,
   input  wire logic                   collision_i,
   // configuration load after reset
   input  wire logic                   cfg_load_i,
   input  wire logic [15:0]            cfg_load_data_i,
   // results
   output logic                        irq_o,
   output logic                        tx_abandon_o
);
   ebi_pkg::ebi_bus_state_t state_reg;
   ebi_pkg::ebi_bus_state_t state_next;
   logic                    ack_reg;
   logic                    ack_next;
   logic [31:0]             dat_reg;
   logic [31:0]             dat_next;
   ebi_pkg::ebi_word_t      cfg_reg;
   ebi_pkg::ebi_word_t      cfg_next;
   logic                    irq_reg;
   logic                    irq_next;
   logic                    abandon_reg;
   logic                    abandon_next;

   logic                    acc;
   logic                    acc_wr;
   logic                    acc_rd;
   logic                    hit_cfg;
   logic                    hit_evt;
   logic                    hit_lost;
   logic                    hit_coll;
   logic                    soft_req;
   ebi_pkg::ebi_word_t      flags;
   ebi_pkg::ebi_word_t      flag_set;
   ebi_pkg::ebi_word_t      flag_clr;
   logic [`EBI_CNT_W-1:0]   lost_count;
   logic [`EBI_CNT_W-1:0]   coll_count;
   logic                    lost_half;
   logic                    coll_half;

   // access decode: an access is taken once, at the edge that raises ack
   assign acc      = wb_cyc_i && wb_stb_i && (state_reg == ebi_pkg::EBI_IDLE);
   assign acc_wr   = acc && wb_we_i;
   assign acc_rd   = acc && !wb_we_i;
   assign hit_cfg  = (wb_adr_i == `EBI_ADR_CONFIG);
   assign hit_evt  = (wb_adr_i == `EBI_ADR_EVENT);
   assign hit_lost = (wb_adr_i == `EBI_ADR_LOST);
   assign hit_coll = (wb_adr_i == `EBI_ADR_COLL);

   // the request bit is never stored, so each written one acts once
   assign soft_req = acc_wr && hit_cfg && wb_sel_i[0]
                     && wb_dat_i[`EBI_BIT_SOFT];

   // event sources
   always_comb begin
      flag_set                      = '0;
      flag_set[`EBI_BIT_SOFT]       = soft_req;
      flag_set[`EBI_BIT_TX_READY]   = tx_ready_i;
      flag_set[`EBI_BIT_TX_STARVE]  = tx_starve_i;
      flag_set[`EBI_BIT_RX_LOST]    = rx_lost_i;
      flag_set[`EBI_BIT_RX_EARLY]   = rx_early_i;
      flag_set[`EBI_BIT_COLL_HALF]  = coll_half;
      flag_set[`EBI_BIT_LOST_HALF]  = lost_half;
      flag_set[`EBI_BIT_ADDR_MATCH] = addr_match_i;
      // reading the event register clears every flag
      flag_clr = (acc_rd && hit_evt) ? 16'hffff : 16'h0000;
      // with match enabled the early event takes the place of the match report
      if (rx_early_i && cfg_reg[`EBI_BIT_ADDR_MATCH]) begin
         flag_clr[`EBI_BIT_ADDR_MATCH] = 1'b1;
      end
   end

   ebi_event_flags #(
      .N       (16)
   ) u_flags (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .set_i   (flag_set),
      .clr_i   (flag_clr),
      .flags_o (flags)
   );

   ebi_half_counter #(
      .W         (`EBI_CNT_W),
      .HALF_FROM (`EBI_CNT_HALF_FROM)
   ) u_lost (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .inc_i     (rx_lost_i),
      .clr_i     (acc_rd && hit_lost),
      .count_o   (lost_count),
      .half_o    (lost_half)
   );

   ebi_half_counter #(
      .W         (`EBI_CNT_W),
      .HALF_FROM (`EBI_CNT_HALF_FROM)
   ) u_coll (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .inc_i     (collision_i),
      .clr_i     (acc_rd && hit_coll),
      .count_o   (coll_count),
      .half_o    (coll_half)
   );

   // bus, configuration and outputs
   always_comb begin
      state_next   = state_reg;
      ack_next     = 1'b0;
      dat_next     = dat_reg;
      cfg_next     = cfg_reg;
      abandon_next = tx_starve_i;
      case (state_reg)
         ebi_pkg::EBI_IDLE: begin
            if (acc) begin
               state_next = ebi_pkg::EBI_ACK;
               ack_next   = 1'b1;
            end
         end
         ebi_pkg::EBI_ACK: begin
            state_next = ebi_pkg::EBI_IDLE;
         end
         default: begin
            state_next = ebi_pkg::EBI_IDLE;
         end
      endcase
      if (cfg_load_i) begin
         cfg_next = cfg_load_data_i & `EBI_CFG_WMASK;
      end
      // bit 7 and bit 6 are not stored; upper lane holds the enables
      if (acc_wr && hit_cfg && wb_sel_i[1]) begin
         cfg_next = {wb_dat_i[15:8], 8'h00} & `EBI_CFG_WMASK;
      end
      if (acc_rd) begin
         if (hit_cfg) begin
            dat_next = {16'h0000, cfg_reg[15:8], 2'b00, `EBI_ID_CONFIG};
         end else if (hit_evt) begin
            dat_next = {16'h0000, flags[15:`EBI_BIT_SOFT] & 10'(`EBI_EVT_MASK >> `EBI_BIT_SOFT),
                        `EBI_ID_EVENT};
         end else if (hit_lost) begin
            dat_next = {16'h0000, lost_count, `EBI_ID_LOST};
         end else if (hit_coll) begin
            dat_next = {16'h0000, coll_count, `EBI_ID_COLL};
         end else begin
            dat_next = 32'h0000_0000;
         end
      end else if (acc_wr) begin
         dat_next = 32'h0000_0000;
      end
      // soft flag always passes; the others need their enable
      irq_next = |(flags & (cfg_reg | `EBI_SOFT_MASK));
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg   <= ebi_pkg::EBI_IDLE;
         ack_reg     <= 1'b0;
         dat_reg     <= 32'h0000_0000;
         cfg_reg     <= `EBI_CFG_RESET;
         irq_reg     <= 1'b0;
         abandon_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         ack_reg     <= ack_next;
         dat_reg     <= dat_next;
         cfg_reg     <= cfg_next;
         irq_reg     <= irq_next;
         abandon_reg <= abandon_next;
      end
   end

   assign wb_ack_o     = ack_reg;
   assign wb_dat_o     = dat_reg;
   assign irq_o        = irq_reg;
   assign tx_abandon_o = abandon_reg;

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_cfg_id_read: assert property (
      acc_rd && hit_cfg |=> wb_ack_o && wb_dat_o[5:0] == `EBI_ID_CONFIG
                            && !wb_dat_o[6] && !wb_dat_o[7])
      else $error("config read lost its identifier");

   a_soft_irq_raise: assert property (
      soft_req |=> flags[`EBI_BIT_SOFT] ##1 irq_o)
      else $error("soft request did not raise the interrupt");

   a_soft_act_once: assert property (
      acc_wr && hit_cfg && !soft_req ##1 !acc_rd[*1]
      |-> !flags[`EBI_BIT_SOFT] || $past(flags[`EBI_BIT_SOFT]))
      else $error("soft flag set without a written one");

   a_enable_gate: assert property (
      (flags & (cfg_reg | `EBI_SOFT_MASK)) == 16'h0000 |=> !irq_o)
      else $error("interrupt raised by a disabled event");

   a_irq_pending: assert property (
      (flags & cfg_reg) != 16'h0000 |=> irq_o)
      else $error("enabled pending event gave no interrupt");

   a_starve_abandon: assert property (
      tx_starve_i |=> tx_abandon_o && flags[`EBI_BIT_TX_STARVE])
      else $error("underrun not flagged or frame not abandoned");

   a_abandon_cause: assert property (
      tx_abandon_o |-> $past(tx_starve_i))
      else $error("frame abandoned without an underrun");

   a_lost_count: assert property (
      rx_lost_i && !(acc_rd && hit_lost)
      |=> lost_count == $past(lost_count) + `EBI_CNT_W'(1)
          && flags[`EBI_BIT_RX_LOST])
      else $error("receive miss not counted");

   a_coll_half: assert property (
      collision_i && coll_count == `EBI_CNT_HALF_FROM && !(acc_rd && hit_coll)
      |=> flags[`EBI_BIT_COLL_HALF]
          ##1 (irq_o || !$past(cfg_reg[`EBI_BIT_COLL_HALF])))
      else $error("collision half-way step missed");

   a_lost_half: assert property (
      $rose(flags[`EBI_BIT_LOST_HALF]) |-> $past(lost_count) == `EBI_CNT_HALF_FROM)
      else $error("miss half-way flag at wrong count");

   a_early_swap: assert property (
      rx_early_i && cfg_reg[`EBI_BIT_ADDR_MATCH] && !addr_match_i
      |=> !flags[`EBI_BIT_ADDR_MATCH] && flags[`EBI_BIT_RX_EARLY])
      else $error("match report did not turn into the early event");

   a_read_clear: assert property (
      acc_rd && hit_evt && flag_set == 16'h0000 |=> flags == 16'h0000)
      else $error("event read did not clear the flags");

   a_cfg_load: assert property (
      cfg_load_i && !(acc_wr && hit_cfg && wb_sel_i[1])
      |=> cfg_reg == ($past(cfg_load_data_i) & `EBI_CFG_WMASK))
      else $error("configuration load not taken");

   a_ack_single: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   c_soft_irq:   cover property (soft_req ##2 irq_o);
   c_starve:     cover property (tx_starve_i ##1 tx_abandon_o);
   c_coll_half:  cover property (coll_half);
   c_early_swap: cover property (addr_match_i ##[1:20] rx_early_i);
endmodule // ebi_top

// File: ebi_map.svh
// register map, field positions and reset values of the buffer interrupt enable block
`ifndef EBI_MAP_SVH
`define EBI_MAP_SVH

// register indices; the byte address is four times the index
`define EBI_IDX_CONFIG     9'h10a
`define EBI_IDX_EVENT      9'h12c
`define EBI_IDX_LOST       9'h130
`define EBI_IDX_COLL       9'h132
`define EBI_ADR_W          12
`define EBI_ADR_CONFIG     {1'b0, `EBI_IDX_CONFIG, 2'b00}
`define EBI_ADR_EVENT      {1'b0, `EBI_IDX_EVENT, 2'b00}
`define EBI_ADR_LOST       {1'b0, `EBI_IDX_LOST, 2'b00}
`define EBI_ADR_COLL       {1'b0, `EBI_IDX_COLL, 2'b00}

// internal register identifiers in bits 5:0
`define EBI_ID_CONFIG      6'h0b
`define EBI_ID_EVENT       6'h0c
`define EBI_ID_LOST        6'h10
`define EBI_ID_COLL        6'h12

// bit positions shared by the enable and event registers
`define EBI_BIT_SOFT       6
`define EBI_BIT_TX_READY   8
`define EBI_BIT_TX_STARVE  9
`define EBI_BIT_RX_LOST    10
`define EBI_BIT_RX_EARLY   11
`define EBI_BIT_COLL_HALF  12
`define EBI_BIT_LOST_HALF  13
`define EBI_BIT_ADDR_MATCH 15

`define EBI_CFG_WMASK      16'hbf00
`define EBI_CFG_RESET      16'h0000
`define EBI_EVT_MASK       16'hbf40
`define EBI_SOFT_MASK      16'h0040
`define EBI_FLAGS_RESET    16'h0000

// counters: width and the value from which the half-way step starts
`define EBI_CNT_W          10
`define EBI_CNT_HALF_FROM  10'h1ff
`define EBI_CNT_RESET      10'h000

`endif

// File: ebi_pkg.sv
// types of the buffer interrupt enable block
package ebi_pkg;
   typedef enum logic {EBI_IDLE, EBI_ACK} ebi_bus_state_t;
   typedef logic [15:0] ebi_word_t;
endpackage

// File: ebi_event_flags.sv
// sticky event flags, set wins over clear
`timescale 1ns/1ps
`include "ebi_map.svh"
module ebi_event_flags #(
   parameter int N = 16
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // per flag set and clear
   input  wire logic [N-1:0] set_i,
   input  wire logic [N-1:0] clr_i,
   // flag state
   output logic      [N-1:0] flags_o
);
   logic [N-1:0] flags_reg;
   logic [N-1:0] flags_next;

   for (genvar i = 0; i < N; i++) begin : g_flag
      always_comb begin
         if (set_i[i]) begin
            flags_next[i] = 1'b1;
         end else if (clr_i[i]) begin
            flags_next[i] = 1'b0;
         end else begin
            flags_next[i] = flags_reg[i];
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            flags_reg[i] <= 1'b0;
         end else begin
            flags_reg[i] <= flags_next[i];
         end
      end
   end

   assign flags_o = flags_reg;
endmodule // ebi_event_flags

// File: ebi_half_counter.sv
// wrapping event counter, cleared on read, flags the half-way step
`timescale 1ns/1ps
`include "ebi_map.svh"
module ebi_half_counter #(
   parameter int               W         = `EBI_CNT_W,
   parameter logic [W-1:0]     HALF_FROM = `EBI_CNT_HALF_FROM
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // count and clear strobes
   input  wire logic         inc_i,
   input  wire logic         clr_i,
   // state
   output logic      [W-1:0] count_o,
   output logic              half_o
);
   logic [W-1:0] count_reg;
   logic [W-1:0] count_next;

   always_comb begin
      if (clr_i) begin
         count_next = inc_i ? W'(1) : '0;
      end else if (inc_i) begin
         count_next = count_reg + W'(1);
      end else begin
         count_next = count_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   // the step onto the half-way value, lost if the same cycle clears the count
   assign half_o  = inc_i && !clr_i && (count_reg == HALF_FROM);
   assign count_o = count_reg;
endmodule // ebi_half_counter

// File: tb_ebi_top.sv
// self-checking testbench of the buffer interrupt enable block
`timescale 1ns/1ps
`include "ebi_map.svh"
module tb_ebi_top;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
   logic [11:0] wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic        wb_ack_o, irq_o, tx_abandon_o, cfg_load_i;
   logic [15:0] cfg_load_data_i, q, r;
   logic [5:0]  ev;
   int          err_total, num_checks, mcfg, mflags, mlost, mcoll, n;
   int          exp_q[$];

   ebi_top ebi_top_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_ready_i(ev[0]), .tx_starve_i(ev[1]),
      .rx_lost_i(ev[2]), .rx_early_i(ev[3]), .addr_match_i(ev[4]), .collision_i(ev[5]),
      .cfg_load_i(cfg_load_i), .cfg_load_data_i(cfg_load_data_i), .irq_o(irq_o),
      .tx_abandon_o(tx_abandon_o));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // one classic cycle; the model follows the write at the ack edge
   task automatic wb(input logic we, input logic [11:0] a, input logic [3:0] s,
                     input logic [15:0] d, output logic [15:0] rd);
      int k;
      k = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= {16'h0000, d};
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      if (k >= 50) begin
         err_total++;
         $display("mismatch wb_ack expected 1 seen 0");
      end
      rd = wb_dat_o[15:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      if (we && a == `EBI_ADR_CONFIG) begin
         if (s[1]) mcfg = d & 16'hbf00;
         if (s[0] && d[6]) mflags[6] = 1'b1;
      end
   endtask

   function automatic logic [15:0] rd_exp(input logic [11:0] a);
      case (a)
         `EBI_ADR_CONFIG: return mcfg[15:0] | 16'h000b;
         `EBI_ADR_EVENT:  return (mflags[15:0] & 16'hbf40) | 16'h000c;
         `EBI_ADR_LOST:   return {mlost[9:0], 6'h10};
         `EBI_ADR_COLL:   return {mcoll[9:0], 6'h12};
         default:         return 16'h0000;
      endcase
   endfunction

   // read with expectation, then apply read-clear in the model
   task automatic rd(input logic [11:0] a, input string nm);
      exp_q.push_back(rd_exp(a));
      wb(1'b0, a, 4'h3, 16'h0000, q);
      if (a == `EBI_ADR_EVENT) mflags = 0;
      if (a == `EBI_ADR_LOST) mlost = 0;
      if (a == `EBI_ADR_COLL) mcoll = 0;
      chk(nm, q, 16'(exp_q.pop_front()));
   endtask

   function automatic void model(input logic [5:0] e);
      if (e[0]) mflags[8] = 1'b1;
      if (e[1]) mflags[9] = 1'b1;
      if (e[2]) begin
         mflags[10] = 1'b1;
         if (mlost == 'h1ff) mflags[13] = 1'b1;
         mlost = (mlost + 1) & 'h3ff;
      end
      if (e[3]) mflags[11] = 1'b1;
      if (e[3] && !e[4] && mcfg[15]) mflags[15] = 1'b0;
      if (e[4]) mflags[15] = 1'b1;
      if (e[5]) begin
         if (mcoll == 'h1ff) mflags[12] = 1'b1;
         mcoll = (mcoll + 1) & 'h3ff;
      end
   endfunction

   // hold event pulses for cnt back-to-back edges
   task automatic hit(input logic [5:0] e, input int cnt);
      @(posedge clk_i);
      ev <= e;
      repeat (cnt) begin
         @(posedge clk_i);
         model(e);
      end
      ev <= 6'h00;
   endtask

   task automatic settle(input logic ab);
      @(posedge clk_i);
      chk("tx_abandon", {15'h0, tx_abandon_o}, {15'h0, ab});
      @(posedge clk_i);
      chk("irq", {15'h0, irq_o}, {15'h0, |(mflags[15:0] & (mcfg[15:0] | 16'h0040))});
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      tally_and_finish();
   end

   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, cfg_load_i} = 5'b10000;
      {wb_adr_i, wb_sel_i, wb_dat_i, cfg_load_data_i, ev} = '0;
      {err_total, num_checks, mcfg, mflags, mlost, mcoll} = '0;
      void'($urandom(51));
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`EBI_ADR_CONFIG, "cfg_reset");
      rd(`EBI_ADR_EVENT, "evt_reset");
      rd(`EBI_ADR_LOST, "lost_reset");
      rd(`EBI_ADR_COLL, "coll_reset");
      rd(12'h004, "unmapped");
      settle(1'b0);
      // every enable and the soft request, reserved bit kept at zero
      wb(1'b1, `EBI_ADR_CONFIG, 4'h3, 16'hff7f, q);
      wb(1'b1, `EBI_ADR_EVENT, 4'h3, 16'hff7f, q);
      wb(1'b1, 12'h004, 4'h3, 16'h0000, q);
      rd(`EBI_ADR_CONFIG, "cfg_all");
      rd(`EBI_ADR_EVENT, "evt_soft");
      $display("test registers done");
      wb(1'b1, `EBI_ADR_CONFIG, 4'h3, 16'h0040, q);
      settle(1'b0);
      rd(`EBI_ADR_EVENT, "evt_soft1");
      settle(1'b0);
      settle(1'b0);
      wb(1'b1, `EBI_ADR_CONFIG, 4'h2, 16'h0040, q);
      settle(1'b0);
      wb(1'b1, `EBI_ADR_CONFIG, 4'h3, 16'h0040, q);
      settle(1'b0);
      rd(`EBI_ADR_EVENT, "evt_soft2");
      $display("test soft request done");
      for (int k = 0; k < 15; k++) begin
         // receive dma is never selected here, so a random early enable is legal
         r = 16'($urandom()) & 16'hbf00;
         wb(1'b1, `EBI_ADR_CONFIG, 4'h3, r, q);
         // an underrun pass is always followed by a receive miss pass
         hit(6'h01 << (k % 5), 1);
         settle(k % 5 == 1);
         rd(`EBI_ADR_EVENT, "evt_each");
         settle(1'b0);
      end
      $display("test event enables done");
      wb(1'b1, `EBI_ADR_CONFIG, 4'h3, 16'h8800, q);
      hit(6'h10, 1);
      settle(1'b0);
      hit(6'h08, 1);
      settle(1'b0);
      rd(`EBI_ADR_EVENT, "evt_to_early");
      hit(6'h18, 1);
      rd(`EBI_ADR_EVENT, "evt_both");
      $display("test address match done");
      n = $urandom_range(40, 1);
      hit(6'h24, n);
      rd(`EBI_ADR_LOST, "lost_count");
      rd(`EBI_ADR_COLL, "coll_count");
      rd(`EBI_ADR_EVENT, "evt_lost");
      wb(1'b1, `EBI_ADR_CONFIG, 4'h3, 16'h2000, q);
      hit(6'h24, 'h200);
      settle(1'b0);
      rd(`EBI_ADR_LOST, "lost_half");
      wb(1'b1, `EBI_ADR_CONFIG, 4'h3, 16'h1000, q);
      settle(1'b0);
      rd(`EBI_ADR_COLL, "coll_half");
      rd(`EBI_ADR_EVENT, "evt_half");
      $display("test counters done");
      r = 16'($urandom());
      @(posedge clk_i);
      cfg_load_i      <= 1'b1;
      cfg_load_data_i <= r;
      @(posedge clk_i);
      cfg_load_i <= 1'b0;
      mcfg = r & 16'hbf00;
      rd(`EBI_ADR_CONFIG, "cfg_load");
      $display("test config load done");
      tally_and_finish();
   end
endmodule // tb_ebi_top
